// File: hw/osd_ctrl_pkg.sv
/*
  Constants, field positions and carrier types for the display-control
  command decoder. Assumes a single 100 MHz system clock and a serial
  link whose clock is sampled as an ordinary asynchronous input.
*/
package osd_ctrl_pkg;

  // ==========================================================================
  // Command codes and byte layout
  // ==========================================================================
  localparam int          BYTE_W        = 8;
  localparam int          CODE_HI       = 7;
  localparam int          CODE_LO       = 4;
  localparam int          FIRST_BIT     = 7;
  localparam logic [3:0]  CODE_ADDR_SET = 4'h8;
  localparam logic [3:0]  CODE_COLOUR   = 4'hD;
  localparam logic [3:0]  CODE_SYNC     = 4'hE;
  localparam logic [3:0]  CODE_PORT     = 4'hF;
  localparam logic [7:0]  REG_RESET     = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int PH_LO = 0;
  localparam int PH_HI = 2;
  localparam int BURST_HALT_BIT = 3;
  localparam int BG_OFF_BIT     = 4;
  localparam int SILENCE_BIT    = 0;
  localparam int LINE_SEL_BIT   = 1;
  localparam int SYNC_SEL0_BIT  = 2;
  localparam int SYNC_SEL1_BIT  = 3;
  localparam int LOSS_LO = 0;
  localparam int LOSS_HI = 3;
  localparam int REC_LO  = 4;
  localparam int REC_HI  = 6;
  localparam int PORT_LVL0_BIT = 0;
  localparam int PORT_SEL0_BIT = 1;
  localparam int PORT_LVL1_BIT = 2;
  localparam int PORT_SEL1_BIT = 3;

  // ==========================================================================
  // Display geometry and hysteresis counts
  // ==========================================================================
  localparam int          GRID_COLS  = 24;
  localparam int          GRID_ROWS  = 12;
  localparam int          GRID_CHARS = GRID_COLS * GRID_ROWS;
  localparam logic [3:0]  ROWS_FULL  = 4'hC;
  localparam logic [3:0]  ROWS_SHORT = 4'hA;
  localparam logic [3:0]  ROW_MAX    = 4'hB;
  localparam logic [4:0]  COL_MAX    = 5'h17;
  localparam int          CNT_W      = 9;
  localparam logic [8:0]  LOSS_32    = 9'h020;
  localparam logic [8:0]  LOSS_64    = 9'h040;
  localparam logic [8:0]  LOSS_128   = 9'h080;
  localparam logic [8:0]  LOSS_256   = 9'h100;
  localparam logic [8:0]  REC_4      = 9'h004;
  localparam logic [8:0]  REC_8      = 9'h008;
  localparam logic [8:0]  REC_16     = 9'h010;
  localparam logic [8:0]  CNT_ZERO   = 9'h000;

  // Background phase field codes, and the phases they select in eighths of a turn.
  localparam logic [2:0] PH_CODE_HALF    = 3'h0;
  localparam logic [2:0] PH_CODE_3HALF   = 3'h2;
  localparam logic [2:0] PH_CODE_PI      = 3'h3;
  localparam logic [2:0] PH_CODE_3QUART  = 3'h4;
  localparam logic [2:0] PHASE_HALF_PI   = 3'h2;
  localparam logic [2:0] PHASE_3HALF_PI  = 3'h6;
  localparam logic [2:0] PHASE_PI        = 3'h4;
  localparam logic [2:0] PHASE_3QUART_PI = 3'h3;

  typedef enum logic [1:0] {
    SEL_ADDR,
    SEL_COLOUR,
    SEL_SYNC,
    SEL_PORT
  } cmd_sel_e;

  // Decoded control state seen by the video logic.
  typedef struct packed {
    logic [2:0] bgPhase;
    logic       bgPhaseValid;
    logic       burstOn;
    logic       bgColourOn;
    logic       videoSilence;
    logic [3:0] linesShown;
    logic       tvStandardHi;
    logic       internalSync;
  } video_ctrl_s;

  // Sampled video timing inputs.
  typedef struct packed {
    logic lineTick;
    logic syncSeen;
    logic compSync;
    logic sepSync;
    logic charBorder;
  } video_timing_s;

endpackage : osd_ctrl_pkg

// File: hw/osd_sync_display_control.sv
/*
  Command decoder and control registers for the colour/standard, sync
  control and port output commands, plus the sync pin muxing. Assumes
  video timing inputs arrive from outside clk's domain and the serial
  link is driven by a host with a slow clock.
*/
`timescale 1ns/1ps
module osd_sync_display_control (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // Serial command link
  input  wire logic                        csN,
  input  wire logic                        sclk,
  input  wire logic                        sin,
  // Video timing from the video front end
  input  wire osd_ctrl_pkg::video_timing_s timingIn,
  // Controls to the video path
  output osd_ctrl_pkg::video_ctrl_s        videoCtrl,
  output logic                             syncPresent,
  // Address command fields for the display memory side
  output logic [3:0]                       rowAddr,
  output logic [4:0]                       colAddr,
  output logic                             addrInRange,
  // Sync pins
  output logic                             composite_sync_pin,
  output logic                             separated_sync_pin
);

  // ==========================================================================
  // Serial byte receiver
  // ==========================================================================
  logic [7:0] rxByte;
  logic       rxValid;
  logic       csIdle;

  serial_byte_rx u_rx (
    .clk    (clk),
    .rstn   (rstn),
    .csN    (csN),
    .sclk   (sclk),
    .sin    (sin),
    .rxByte (rxByte),
    .rxValid(rxValid),
    .csIdle (csIdle)
  );

  // ==========================================================================
  // Command registers
  // ==========================================================================
  logic [7:0]             standard_sync_select_first_reg, standard_sync_select_first_next;
  logic [7:0]             background_colour_control_reg, background_colour_control_next;
  logic [7:0]             sync_output_control_reg, sync_output_control_next;
  logic [7:0]             sync_detect_hysteresis_reg, sync_detect_hysteresis_next;
  logic [7:0]             port_output_control_reg, port_output_control_next;
  logic [3:0]             row_reg, row_next;
  logic [4:0]             col_reg, col_next;
  osd_ctrl_pkg::cmd_sel_e sel_reg, sel_next;

  // Command code of a first byte mapped to the selector.
  function automatic osd_ctrl_pkg::cmd_sel_e decodeCode(input logic [3:0] code);
    unique case (code)
      osd_ctrl_pkg::CODE_COLOUR: decodeCode = osd_ctrl_pkg::SEL_COLOUR;
      osd_ctrl_pkg::CODE_SYNC:   decodeCode = osd_ctrl_pkg::SEL_SYNC;
      osd_ctrl_pkg::CODE_PORT:   decodeCode = osd_ctrl_pkg::SEL_PORT;
      default:                   decodeCode = osd_ctrl_pkg::SEL_ADDR;
    endcase
  endfunction : decodeCode

  // Byte decode. Codes other than the three handled here park the decoder
  // on the address command, so their data bytes load the column field.
  always_comb begin
    standard_sync_select_first_next = standard_sync_select_first_reg;
    background_colour_control_next  = background_colour_control_reg;
    sync_output_control_next        = sync_output_control_reg;
    sync_detect_hysteresis_next     = sync_detect_hysteresis_reg;
    port_output_control_next        = port_output_control_reg;
    row_next                        = row_reg;
    col_next                        = col_reg;
    sel_next                        = sel_reg;
    if (csIdle) begin
      sel_next = osd_ctrl_pkg::SEL_ADDR;
    end else if (rxValid) begin
      if (rxByte[osd_ctrl_pkg::FIRST_BIT]) begin
        sel_next = decodeCode(rxByte[osd_ctrl_pkg::CODE_HI:osd_ctrl_pkg::CODE_LO]);
        unique case (decodeCode(rxByte[osd_ctrl_pkg::CODE_HI:osd_ctrl_pkg::CODE_LO]))
          osd_ctrl_pkg::SEL_COLOUR: standard_sync_select_first_next = rxByte;
          osd_ctrl_pkg::SEL_SYNC:   sync_output_control_next        = rxByte;
          osd_ctrl_pkg::SEL_PORT:   port_output_control_next        = rxByte;
          osd_ctrl_pkg::SEL_ADDR: begin
            if (rxByte[osd_ctrl_pkg::CODE_HI:osd_ctrl_pkg::CODE_LO]
                == osd_ctrl_pkg::CODE_ADDR_SET) begin
              row_next = rxByte[3:0];
            end
          end
        endcase
      end else begin
        // Data byte reuses the stored command code.
        unique case (sel_reg)
          osd_ctrl_pkg::SEL_COLOUR: background_colour_control_next = rxByte;
          osd_ctrl_pkg::SEL_SYNC:   sync_detect_hysteresis_next    = rxByte;
          osd_ctrl_pkg::SEL_PORT:   port_output_control_next       = port_output_control_reg;
          osd_ctrl_pkg::SEL_ADDR:   col_next                       = rxByte[4:0];
        endcase
      end
    end
  end

  // Every command register clears on reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standard_sync_select_first_reg <= osd_ctrl_pkg::REG_RESET;
      background_colour_control_reg  <= osd_ctrl_pkg::REG_RESET;
      sync_output_control_reg        <= osd_ctrl_pkg::REG_RESET;
      sync_detect_hysteresis_reg     <= osd_ctrl_pkg::REG_RESET;
      port_output_control_reg        <= osd_ctrl_pkg::REG_RESET;
      row_reg                        <= 4'h0;
      col_reg                        <= 5'h00;
      sel_reg                        <= osd_ctrl_pkg::SEL_ADDR;
    end else begin
      standard_sync_select_first_reg <= standard_sync_select_first_next;
      background_colour_control_reg  <= background_colour_control_next;
      sync_output_control_reg        <= sync_output_control_next;
      sync_detect_hysteresis_reg     <= sync_detect_hysteresis_next;
      port_output_control_reg        <= port_output_control_next;
      row_reg                        <= row_next;
      col_reg                        <= col_next;
      sel_reg                        <= sel_next;
    end
  end

  assign rowAddr     = row_reg;
  assign colAddr     = col_reg;
  assign addrInRange = (row_reg <= osd_ctrl_pkg::ROW_MAX) &&
                       (col_reg <= osd_ctrl_pkg::COL_MAX);

  // ==========================================================================
  // Video timing synchronisers
  // ==========================================================================
  osd_ctrl_pkg::video_timing_s tMeta_reg, tSync_reg, tLast_reg;
  osd_ctrl_pkg::video_timing_s tMeta_next, tSync_next, tLast_next;

  always_comb begin
    tMeta_next = timingIn;
    tSync_next = tMeta_reg;
    tLast_next = tSync_reg;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tMeta_reg <= '0;
      tSync_reg <= '0;
      tLast_reg <= '0;
    end else begin
      tMeta_reg <= tMeta_next;
      tSync_reg <= tSync_next;
      tLast_reg <= tLast_next;
    end
  end

  // ==========================================================================
  // Sync hysteresis thresholds
  // ==========================================================================
  logic [osd_ctrl_pkg::CNT_W-1:0] lossLimit, recoverLimit;
  logic                           lineEdge;

  // Only the one-hot loss codes are honoured; others disable loss detection.
  always_comb begin
    unique case (sync_detect_hysteresis_reg[osd_ctrl_pkg::LOSS_HI:osd_ctrl_pkg::LOSS_LO])
      4'h1:    lossLimit = osd_ctrl_pkg::LOSS_32;
      4'h2:    lossLimit = osd_ctrl_pkg::LOSS_64;
      4'h4:    lossLimit = osd_ctrl_pkg::LOSS_128;
      4'h8:    lossLimit = osd_ctrl_pkg::LOSS_256;
      default: lossLimit = osd_ctrl_pkg::CNT_ZERO;
    endcase
    unique case (sync_detect_hysteresis_reg[osd_ctrl_pkg::REC_HI:osd_ctrl_pkg::REC_LO])
      3'h1:    recoverLimit = osd_ctrl_pkg::REC_4;
      3'h2:    recoverLimit = osd_ctrl_pkg::REC_8;
      3'h4:    recoverLimit = osd_ctrl_pkg::REC_16;
      default: recoverLimit = osd_ctrl_pkg::CNT_ZERO;
    endcase
  end

  assign lineEdge = tSync_reg.lineTick && !tLast_reg.lineTick;

  sync_hysteresis #(
    .CNT_W(osd_ctrl_pkg::CNT_W)
  ) u_hyst (
    .clk         (clk),
    .rstn        (rstn),
    .lineTick    (lineEdge),
    .syncSeen    (tSync_reg.syncSeen),
    .lossLimit   (lossLimit),
    .recoverLimit(recoverLimit),
    .syncPresent (syncPresent)
  );

  // ==========================================================================
  // Video controls and sync pins
  // ==========================================================================
  osd_ctrl_pkg::video_ctrl_s ctrl_reg, ctrl_next;
  logic                      csPin_reg, csPin_next, sepPin_reg, sepPin_next;

  // Registered outputs keep pin glitches from combinational muxing away.
  always_comb begin
    ctrl_next              = '0;
    ctrl_next.bgPhaseValid = 1'b1;
    unique case (background_colour_control_reg[osd_ctrl_pkg::PH_HI:osd_ctrl_pkg::PH_LO])
      osd_ctrl_pkg::PH_CODE_HALF:   ctrl_next.bgPhase = osd_ctrl_pkg::PHASE_HALF_PI;
      osd_ctrl_pkg::PH_CODE_3HALF:  ctrl_next.bgPhase = osd_ctrl_pkg::PHASE_3HALF_PI;
      osd_ctrl_pkg::PH_CODE_PI:     ctrl_next.bgPhase = osd_ctrl_pkg::PHASE_PI;
      osd_ctrl_pkg::PH_CODE_3QUART: ctrl_next.bgPhase = osd_ctrl_pkg::PHASE_3QUART_PI;
      default: begin
        ctrl_next.bgPhase      = osd_ctrl_pkg::PHASE_HALF_PI;
        ctrl_next.bgPhaseValid = 1'b0;
      end
    endcase
    ctrl_next.burstOn      = !background_colour_control_reg[osd_ctrl_pkg::BURST_HALT_BIT];
    ctrl_next.bgColourOn   = !background_colour_control_reg[osd_ctrl_pkg::BG_OFF_BIT];
    ctrl_next.videoSilence = sync_output_control_reg[osd_ctrl_pkg::SILENCE_BIT];
    ctrl_next.linesShown   = sync_output_control_reg[osd_ctrl_pkg::LINE_SEL_BIT] ?
                             osd_ctrl_pkg::ROWS_SHORT : osd_ctrl_pkg::ROWS_FULL;
    ctrl_next.tvStandardHi = standard_sync_select_first_reg[3];
    ctrl_next.internalSync = standard_sync_select_first_reg[0];
    if (port_output_control_reg[osd_ctrl_pkg::PORT_SEL0_BIT]) begin
      csPin_next = port_output_control_reg[osd_ctrl_pkg::PORT_LVL0_BIT];
    end else if (sync_output_control_reg[osd_ctrl_pkg::SYNC_SEL0_BIT]) begin
      csPin_next = tSync_reg.charBorder;
    end else begin
      csPin_next = tSync_reg.compSync;
    end
    if (port_output_control_reg[osd_ctrl_pkg::PORT_SEL1_BIT]) begin
      sepPin_next = port_output_control_reg[osd_ctrl_pkg::PORT_LVL1_BIT];
    end else if (sync_output_control_reg[osd_ctrl_pkg::SYNC_SEL1_BIT]) begin
      sepPin_next = ctrl_next.internalSync ? 1'b1 : tSync_reg.sepSync;
    end else begin
      sepPin_next = tSync_reg.sepSync;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg   <= '0;
      csPin_reg  <= 1'b0;
      sepPin_reg <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      csPin_reg  <= csPin_next;
      sepPin_reg <= sepPin_next;
    end
  end

  assign videoCtrl          = ctrl_reg;
  assign composite_sync_pin = csPin_reg;
  assign separated_sync_pin = sepPin_reg;

endmodule : osd_sync_display_control

// File: hw/serial_byte_rx.sv
/*
  Serial byte receiver: samples chip select, serial clock and data with
  the system clock, finds rising clock edges and assembles MSB-first
  bytes. Assumes the link clock is much slower than clk.
*/
`timescale 1ns/1ps
module serial_byte_rx (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Link pins
  input  wire logic       csN,
  input  wire logic       sclk,
  input  wire logic       sin,
  // Byte output
  output logic [7:0]      rxByte,
  output logic            rxValid,
  output logic            csIdle
);

  // ==========================================================================
  // Synchronisers
  // ==========================================================================
  logic [2:0] meta_reg, sync_reg, last_reg;
  logic [2:0] meta_next, sync_next, last_next;
  logic [7:0] shift_reg, shift_next, byte_reg, byte_next;
  logic [2:0] cnt_reg, cnt_next;
  logic       valid_reg, valid_next;

  // Bit counter and shifter; a byte is complete on the eighth rising edge.
  always_comb begin
    meta_next  = {csN, sclk, sin};
    sync_next  = meta_reg;
    last_next  = sync_reg;
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    byte_next  = byte_reg;
    valid_next = 1'b0;
    if (sync_reg[2]) begin
      cnt_next = 3'h0;  // Deselect discards a partial byte.
    end else if (sync_reg[1] && !last_reg[1]) begin
      shift_next = {shift_reg[6:0], sync_reg[0]};
      cnt_next   = cnt_reg + 3'h1;
      if (cnt_reg == 3'h7) begin
        byte_next  = {shift_reg[6:0], sync_reg[0]};
        valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg  <= 3'h7;
      sync_reg  <= 3'h7;
      last_reg  <= 3'h7;
      shift_reg <= 8'h00;
      cnt_reg   <= 3'h0;
      byte_reg  <= 8'h00;
      valid_reg <= 1'b0;
    end else begin
      meta_reg  <= meta_next;
      sync_reg  <= sync_next;
      last_reg  <= last_next;
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      byte_reg  <= byte_next;
      valid_reg <= valid_next;
    end
  end

  assign rxByte  = byte_reg;
  assign rxValid = valid_reg;
  assign csIdle  = sync_reg[2];

endmodule : serial_byte_rx

// File: hw/sync_hysteresis.sv
/*
  External sync presence detector with separate loss and recovery line
  counts. Assumes one lineTick pulse per horizontal line period.
*/
`timescale 1ns/1ps
module sync_hysteresis #(
  parameter int CNT_W = osd_ctrl_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Line timing
  input  wire logic             lineTick,
  input  wire logic             syncSeen,
  // Thresholds, zero meaning none
  input  wire logic [CNT_W-1:0] lossLimit,
  input  wire logic [CNT_W-1:0] recoverLimit,
  // Status
  output logic                  syncPresent
);

  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             present_reg, present_next;

  // Counts consecutive lines that disagree with the current state.
  always_comb begin
    cnt_next     = cnt_reg;
    present_next = present_reg;
    if (present_reg) begin
      if (lossLimit == '0) begin
        cnt_next = '0;
      end else if (lineTick) begin
        if (syncSeen) begin
          cnt_next = '0;
        end else if (cnt_reg + 1'b1 >= lossLimit) begin
          present_next = 1'b0;
          cnt_next     = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
    end else if (lineTick) begin
      if (!syncSeen) begin
        cnt_next = '0;
      end else if (recoverLimit == '0 || cnt_reg + 1'b1 >= recoverLimit) begin
        present_next = 1'b1;
        cnt_next     = '0;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg     <= '0;
      present_reg <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      present_reg <= present_next;
    end
  end

  assign syncPresent = present_reg;

endmodule : sync_hysteresis

// File: test/host_link_model.sv
/* Host model driving the chip-selected serial command link.
   Assumes clk is the bench clock; idle pins rest high as with pull-ups. */
`timescale 1ns/1ps
module host_link_model (
  // Clock
  input  wire logic clk,
  // Link pins
  output logic      csN,
  output logic      sclk,
  output logic      sin
);
  // ==========================================================================
  // Link tasks
  initial begin
    csN  = 1'b1;
    sclk = 1'b1;
    sin  = 1'b1;
  end

  // The gap after a change lets the device's synchroniser settle.
  task automatic select(input logic on);
    @(posedge clk) csN <= !on;
    repeat (8) @(posedge clk);
  endtask : select

  // One byte, MSB first, 40 ns low and 40 ns high per bit.
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) sclk <= 1'b0;
      sin <= b[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk) sin <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : send
endmodule : host_link_model

// File: test/osd_sync_display_control_checker.sv
/* Checker for the display-control decoder, bound to its top module.
   Assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/1ps
module osd_sync_display_control_checker (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rstn,
  // Inputs
  input wire logic                        csN,
  input wire logic                        sclk,
  input wire logic                        sin,
  input wire osd_ctrl_pkg::video_timing_s timingIn,
  // Outputs under watch
  input wire osd_ctrl_pkg::video_ctrl_s   videoCtrl,
  input wire logic                        syncPresent,
  input wire logic [3:0]                  rowAddr,
  input wire logic [4:0]                  colAddr,
  input wire logic                        addrInRange,
  input wire logic                        composite_sync_pin,
  input wire logic                        separated_sync_pin
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  reset_defaults_a:
    assert property ($rose(rstn) |=> videoCtrl.burstOn && videoCtrl.bgColourOn
      && videoCtrl.linesShown == 4'hC && videoCtrl.bgPhase == 3'h2) else $error("bad reset");
  phase_legal_a:
    assert property (videoCtrl.bgPhaseValid |-> videoCtrl.bgPhase inside {3'h2, 3'h6, 3'h4, 3'h3})
      else $error("bad phase");
  lines_legal_a:
    assert property ($past(rstn) |-> videoCtrl.linesShown inside {4'hC, 4'hA}) else $error("bad lines");
  addr_range_a:
    assert property (addrInRange == (rowAddr <= 4'hB && colAddr <= 5'h17)) else $error("bad range");
  idle_hold_a:
    assert property (csN [*8] |-> $stable(videoCtrl)) else $error("change while deselected");
  pins_hold_a:
    assert property ((csN && $stable(timingIn)) [*8] |->
      $stable({composite_sync_pin, separated_sync_pin})) else $error("pin moved");
  sync_hold_a:
    assert property (!timingIn.lineTick [*8] |-> $stable(syncPresent)) else $error("sync moved");
  link_source_a:
    assert property ($changed(videoCtrl) && $past(rstn, 2) |-> !$past(csN, 4) || !$past(csN, 8))
      else $error("change without command");
  cover property ($rose(syncPresent));
  cover property ($rose(videoCtrl.videoSilence));
  cover property ($rose(separated_sync_pin));
endmodule : osd_sync_display_control_checker

bind osd_sync_display_control osd_sync_display_control_checker chk (.clk, .rstn, .csN, .sclk,
  .sin, .timingIn, .videoCtrl, .syncPresent, .rowAddr, .colAddr, .addrInRange,
  .composite_sync_pin, .separated_sync_pin);

// File: test/tb_top.sv
/* Bench: a host model sends commands; a monitor compares each change of
   the watched outputs with the oldest noted value. Assumes note latencies. */
`timescale 1ns/1ps
module tb_top;
  // ==========================================================================
  // Signals
  logic                        clk;
  logic                        rstn;
  logic                        csN;
  logic                        sclk;
  logic                        sin;
  osd_ctrl_pkg::video_timing_s timingIn;
  osd_ctrl_pkg::video_ctrl_s   videoCtrl;
  osd_ctrl_pkg::video_ctrl_s   expCtrl;
  logic                        syncPresent;
  logic                        csPin;
  logic                        sepPin;
  logic [3:0]                  rowAddr;
  logic [4:0]                  colAddr;
  logic                        addrInRange;
  logic                        expSync = 1'b0;
  logic [1:0]                  expPins = 2'h0;
  logic [9:0]                  expAddr = 10'h001;
  logic [26:0]                 prevOut = 27'h0;
  logic [26:0]                 expQ[$];
  int                          miscompares = 0;
  int                          nTests = 0;
  int                          cycles = 0;
  wire logic [26:0]            outNow = {videoCtrl, syncPresent, csPin, sepPin, rowAddr,
                                         colAddr, addrInRange};

  osd_sync_display_control dut (.clk, .rstn, .csN, .sclk, .sin, .timingIn, .videoCtrl,
    .syncPresent, .rowAddr, .colAddr, .addrInRange, .composite_sync_pin(csPin),
    .separated_sync_pin(sepPin));
  host_link_model host (.clk, .csN, .sclk, .sin);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  task automatic note();
    expQ.push_back({expCtrl, expSync, expPins, expAddr});
  endtask : note

  task automatic check(input logic [26:0] e, input logic [26:0] s);
    nTests++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value outputs expected %h seen %h", e, s);
    end
  endtask : check

  // Line periods of 8 clocks; sync is set a clock ahead of the tick.
  task automatic lines(input int n, input logic seen);
    timingIn.syncSeen <= seen;
    repeat (n) begin
      @(posedge clk) timingIn.lineTick <= 1'b1;
      repeat (4) @(posedge clk);
      timingIn.lineTick <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : lines

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // An unexpected change meets an unknown note and so always fails.
  always @(posedge clk) begin
    prevOut <= outNow;
    if (rstn && outNow !== prevOut) begin
      check(expQ.size() ? expQ.pop_front() : {27{1'bx}}, outNow);
    end
  end

  // A hang ends the run well past the expected 1400 cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [1:0] r;
    logic [2:0] code [4] = '{3'h2, 3'h3, 3'h4, 3'h0};
    logic [2:0] phase [4] = '{3'h6, 3'h4, 3'h3, 3'h2};
    void'($urandom(32'h2DE14EFE));
    rstn = 1'b0;
    timingIn = 5'h01;
    expCtrl = '{3'h2, 1'b1, 1'b1, 1'b1, 1'b0, 4'hC, 1'b0, 1'b0};
    note();
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    host.select(1'b1);
    expCtrl.tvStandardHi = 1'b1;
    note();
    host.send(8'hD8);
    for (int i = 0; i < 4; i++) begin
      r = 2'($urandom());
      expCtrl.bgPhase = phase[i];
      expCtrl.burstOn = !r[0];
      expCtrl.bgColourOn = !r[1];
      note();
      host.send({3'h0, r, code[i]});
    end
    host.select(1'b0);
    $display("colour test done");
    // Deselecting mid-command returns to addressing, so the next data byte loads the column.
    host.select(1'b1);
    expCtrl.tvStandardHi = 1'b0;
    note();
    host.send(8'hD0);
    host.select(1'b0);
    host.select(1'b1);
    expAddr = {4'h0, 5'h1F, 1'b0};
    note();
    host.send(8'h1F);
    expAddr = {4'hB, 5'h1F, 1'b0};
    note();
    host.send(8'h8B);
    expAddr = {4'hB, 5'h17, 1'b1};
    note();
    host.send(8'h17);
    $display("deselect test done");
    expCtrl.videoSilence = 1'b1;
    expCtrl.linesShown = 4'hA;
    expPins = 2'h2;
    note();
    host.send(8'hE7);
    host.send(8'h11);
    expSync = 1'b1;
    note();
    lines(4, 1'b1);
    expSync = 1'b0;
    note();
    lines(32, 1'b0);
    $display("sync test done");
    expPins = 2'h0;
    note();
    host.send(8'hF2);
    expPins = 2'h3;
    note();
    host.send(8'hFC);
    // The composite pin must follow charBorder once it moves; the separated pin stays at its port level.
    timingIn.compSync <= 1'b1;
    timingIn.sepSync <= 1'b1;
    timingIn.charBorder <= 1'b0;
    expPins = 2'h1;
    note();
    repeat (10) @(posedge clk);
    expPins = 2'h3;
    note();
    host.send(8'hE3);
    host.select(1'b0);
    repeat (20) @(posedge clk);
    check(27'h0, 27'(expQ.size()));
    $display("port test done");
    give_verdict();
  end
endmodule : tb_top
